// ### logic/prad_pkg.sv
/*
 timing action decode package: register offsets, field positions, resets.
 assumes a single core clock and an AHB-Lite register bus.
*/
`default_nettype none
package prad_pkg;
    localparam int NPORT = 4;
    localparam int PW = 2;
    localparam int SEQ_DEPTH = 256;
    localparam int FIFO_DEPTH = 1024;
    localparam int FIFO_AW = 10;
    localparam int DLY_W = 16;
    localparam int STAMP_W = 30;
    // action field positions
    localparam int ACT_CMD_LO = 0;
    localparam int ACT_DLY_LO = 2;
    localparam int ACT_SEQ_LO = 4;
    localparam int ACT_SWAP = 6;
    localparam int ACT_SMAC = 7;
    // command, delay select and sequence codes
    localparam logic [1:0] CMD_NOP = 2'h0;
    localparam logic [1:0] CMD_ONE = 2'h1;
    localparam logic [1:0] CMD_TWO = 2'h2;
    localparam logic [1:0] CMD_TOD = 2'h3;
    localparam logic [1:0] DLY_NONE = 2'h0;
    localparam logic [1:0] DLY_EGR = 2'h1;
    localparam logic [1:0] DLY_IN1 = 2'h2;
    localparam logic [1:0] DLY_IN2 = 2'h3;
    localparam logic [1:0] SEQ_UPD = 2'h1;
    // register byte offsets
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_MISC = 12'h004;
    localparam logic [11:0] OFS_HVMODE = 12'h008;
    localparam logic [11:0] OFS_RSRV = 12'h00C;
    localparam logic [11:0] OFS_POP = 12'h010;
    localparam logic [11:0] OFS_STAMP = 12'h014;
    localparam logic [11:0] OFS_EVT = 12'h018;
    localparam logic [11:0] OFS_PHY = 12'h01C;
    localparam logic [11:0] OFS_PHASE = 12'h020;
    localparam logic [11:0] OFS_SEQIDX = 12'h024;
    localparam logic [11:0] OFS_SEQVAL = 12'h028;
    localparam logic [11:0] OFS_PORTSEL = 12'h02C;
    localparam logic [11:0] OFS_EDLY = 12'h030;
    localparam logic [11:0] OFS_IDLY1 = 12'h034;
    localparam logic [11:0] OFS_IDLY2 = 12'h038;
    localparam logic [11:0] OFS_SAL = 12'h03C;
    localparam logic [11:0] OFS_SAH = 12'h040;
    localparam logic [11:0] OFS_PCFG = 12'h044;
    // stamp value layout: valid 31, ingress flag 30, port 29:28
    localparam int STV_VALID = 31;
    localparam int STV_ING = 30;
    localparam int STV_PORT = 28;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ### logic/prad_seq_table.sv
/*
 per-flow sequence table of 256 entries, flip-flop storage.
 assumes frame and software accesses never hit the same cycle's write.
*/
`default_nettype none
module prad_seq_table
    import prad_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] frmIdx,
    input wire logic frmBump,
    output logic [15:0] frmSeq,
    input wire logic [7:0] swIdx,
    input wire logic swWr,
    input wire logic [15:0] swData,
    output logic [15:0] swSeq
);
    typedef struct packed {
        logic [SEQ_DEPTH-1:0][15:0] seq;
    } prad_seq_t;
    prad_seq_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (frmBump) begin
            nxt_st.seq[frmIdx] = st_ff.seq[frmIdx] + 16'h0001;
        end
        if (swWr) begin
            nxt_st.seq[swIdx] = swData;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign frmSeq = st_ff.seq[frmIdx];
    assign swSeq = st_ff.seq[swIdx];

    chk_seq_bump_inc: assert property (@(posedge clk) disable iff (reset)
        frmBump && !(swWr && swIdx == frmIdx) |=>
        st_ff.seq[$past(frmIdx)] == $past(st_ff.seq[frmIdx]) + 16'h0001)
        else $error("sequence entry not incremented");
    chk_seq_sw_wr: assert property (@(posedge clk) disable iff (reset)
        swWr |=> st_ff.seq[$past(swIdx)] == $past(swData))
        else $error("software sequence write lost");
endmodule
`default_nettype wire

// ### logic/prad_stamp_fifo.sv
/*
 two-step stamp fifo, 1024 entries of 32 bits, flip-flop storage.
 assumes push and pop come from the same clock domain.
*/
`default_nettype none
module prad_stamp_fifo
    import prad_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic push,
    input wire logic [31:0] pushData,
    input wire logic pop,
    output logic [31:0] headData,
    output logic empty,
    output logic full
);
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][31:0] mem;
        logic [FIFO_AW-1:0] wp;
        logic [FIFO_AW-1:0] rp;
        logic [FIFO_AW:0] cnt;
    } prad_fifo_t;
    prad_fifo_t st_ff, nxt_st;
    logic doPush, doPop;

    always_comb begin
        nxt_st = st_ff;
        doPush = push && !full;
        doPop = pop && !empty;
        if (doPush) begin
            nxt_st.mem[st_ff.wp] = pushData;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (doPop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (doPush && !doPop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (doPop && !doPush) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign headData = st_ff.mem[st_ff.rp];
    assign empty = (st_ff.cnt == '0);
    assign full = (st_ff.cnt == (FIFO_AW+1)'(FIFO_DEPTH));

    chk_fifo_bound: assert property (@(posedge clk) disable iff (reset)
        st_ff.cnt <= (FIFO_AW+1)'(FIFO_DEPTH))
        else $error("fifo count past depth");
    chk_fifo_push_cnt: assert property (@(posedge clk) disable iff (reset)
        push && !full && !pop |=> st_ff.cnt == $past(st_ff.cnt) + 1'b1)
        else $error("fifo push not counted");
endmodule
`default_nettype wire

// ### logic/prad_top.sv
/*
 rewriter timing action decode with its register block.
 assumes frame classifier logic on the same clock hands one action field per
 frame strobe, and an AHB-Lite master for software access.
*/
`default_nettype none
module prad_top
    import prad_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic frmValid,
    input wire logic [7:0] rewriteActionField,
    input wire logic [7:0] headerStampLow,
    input wire logic [PW-1:0] rxPort,
    input wire logic [PW-1:0] txPort,
    input wire logic [STAMP_W-1:0] rxStamp,
    input wire logic [STAMP_W-1:0] txStamp,
    input wire logic rsrvNonZero,
    input wire logic [NPORT-1:0] cfOverflow,
    output logic opValid,
    output logic [1:0] opTiming,
    output logic opCfToRx,
    output logic [DLY_W-1:0] opDelay,
    output logic opSeqInsert,
    output logic [15:0] opSeqNum,
    output logic opSwapMac,
    output logic opSmacReplace,
    output logic [47:0] opSmac,
    output logic opCsumDisable,
    output logic [1:0] opDomain
);
    typedef struct packed {
        logic [NPORT-1:0][3:0] modeCfg;
        logic [NPORT-1:0] csumDis;
        logic [7:0] hvMode;
        logic [NPORT-1:0] rsrv;
        logic [31:0] stampVal;
        logic [NPORT-1:0] evt;
        logic [7:0] phyPred;
        logic [NPORT-1:0] phaseEn;
        logic [7:0] seqIdx;
        logic [PW-1:0] portSel;
        logic [NPORT-1:0][DLY_W-1:0] edly;
        logic [NPORT-1:0][DLY_W-1:0] idly1;
        logic [NPORT-1:0][DLY_W-1:0] idly2;
        logic [NPORT-1:0][47:0] smac;
        logic [NPORT-1:0][15:0] pcfg;
        logic aValid;
        logic aWrite;
        logic [11:0] aAddr;
        logic [31:0] rdata;
        logic pend2;
        logic [31:0] ingEntry;
        logic opValid;
        logic [1:0] opTiming;
        logic opCfToRx;
        logic [DLY_W-1:0] opDelay;
        logic opSeqInsert;
        logic [15:0] opSeqNum;
        logic opSwapMac;
        logic opSmacReplace;
        logic [47:0] opSmac;
        logic opCsumDisable;
        logic [1:0] opDomain;
    } prad_state_t;
    prad_state_t st_ff, nxt_st;

    logic [1:0] aCmd, aDly, aSeq;
    logic seqBump, swSeqWr, fifoPush, fifoPop, fifoEmpty, fifoFull;
    logic [31:0] fifoIn, fifoHead;
    logic [15:0] frmSeq, swSeq;
    logic [31:0] wd;
    logic [1:0] tp, rp;

    assign aCmd = rewriteActionField[ACT_CMD_LO+:2];
    assign aDly = rewriteActionField[ACT_DLY_LO+:2];
    assign aSeq = rewriteActionField[ACT_SEQ_LO+:2];
    assign tp = 2'(txPort);
    assign rp = 2'(rxPort);
    assign wd = hwdata;
    assign seqBump = frmValid && aSeq == SEQ_UPD;
    assign swSeqWr = st_ff.aValid && st_ff.aWrite && st_ff.aAddr == OFS_SEQVAL;
    assign fifoPop = st_ff.aValid && st_ff.aWrite && st_ff.aAddr == OFS_POP;

    always_comb begin
        fifoPush = 1'b0;
        fifoIn = RST_ZERO;
        if (frmValid && aCmd == CMD_TWO) begin
            fifoPush = 1'b1;
            fifoIn = {1'b1, 1'b0, tp, txStamp[STV_PORT-1:0]};
        end else if (st_ff.pend2) begin
            fifoPush = 1'b1;
            fifoIn = st_ff.ingEntry;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        // frame decode, one result per frame strobe
        nxt_st.opValid = frmValid;
        if (frmValid) begin
            nxt_st.opTiming = aCmd;
            nxt_st.opCfToRx = aSeq[1] && aCmd == CMD_ONE;
            unique case (aDly)
                DLY_NONE: nxt_st.opDelay = '0;
                DLY_EGR: nxt_st.opDelay = st_ff.edly[tp];
                DLY_IN1: nxt_st.opDelay = st_ff.idly1[rp];
                DLY_IN2: nxt_st.opDelay = st_ff.idly2[rp];
            endcase
            nxt_st.opSeqInsert = aSeq == SEQ_UPD;
            nxt_st.opSeqNum = frmSeq;
            nxt_st.opSwapMac = rewriteActionField[ACT_SWAP];
            nxt_st.opSmacReplace = rewriteActionField[ACT_SMAC];
            nxt_st.opSmac = st_ff.smac[tp];
            nxt_st.opCsumDisable = st_ff.csumDis[tp];
            nxt_st.opDomain = st_ff.modeCfg[tp][3:2];
        end
        // second fifo entry follows the egress one
        nxt_st.pend2 = frmValid && aCmd == CMD_TWO;
        if (frmValid && aCmd == CMD_TWO) begin
            nxt_st.ingEntry = {1'b1, 1'b1, rp, rxStamp[STV_PORT-1:0]};
        end
        // bus address phase capture
        nxt_st.aValid = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            nxt_st.aWrite = hwrite;
            nxt_st.aAddr = haddr[11:0];
        end
        // bus data phase writes, then sticky sets win over clears
        if (st_ff.aValid && st_ff.aWrite) begin
            unique case (st_ff.aAddr)
                OFS_MODE: nxt_st.modeCfg = wd[4*NPORT-1:0];
                OFS_MISC: nxt_st.csumDis = wd[NPORT-1:0];
                OFS_HVMODE: nxt_st.hvMode = wd[7:0];
                OFS_RSRV: nxt_st.rsrv = st_ff.rsrv & ~wd[NPORT-1:0];
                OFS_EVT: nxt_st.evt = st_ff.evt & ~wd[NPORT-1:0];
                OFS_PHY: nxt_st.phyPred = wd[7:0];
                OFS_PHASE: nxt_st.phaseEn = wd[NPORT-1:0];
                OFS_SEQIDX: nxt_st.seqIdx = wd[7:0];
                OFS_PORTSEL: nxt_st.portSel = wd[PW-1:0];
                OFS_EDLY: nxt_st.edly[st_ff.portSel] = wd[DLY_W-1:0];
                OFS_IDLY1: nxt_st.idly1[st_ff.portSel] = wd[DLY_W-1:0];
                OFS_IDLY2: nxt_st.idly2[st_ff.portSel] = wd[DLY_W-1:0];
                OFS_SAL: nxt_st.smac[st_ff.portSel][31:0] = wd;
                OFS_SAH: nxt_st.smac[st_ff.portSel][47:32] = wd[15:0];
                OFS_PCFG: nxt_st.pcfg[st_ff.portSel] = wd[15:0];
                default: nxt_st.aAddr = st_ff.aAddr;
            endcase
        end
        if (fifoPop) begin
            nxt_st.stampVal = fifoEmpty ? RST_ZERO : fifoHead;
        end
        if (frmValid && rsrvNonZero) begin
            nxt_st.rsrv[rp] = 1'b1;
        end
        nxt_st.evt = nxt_st.evt | cfOverflow;
        // read data for the next data phase
        nxt_st.rdata = RST_ZERO;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[11:0])
                OFS_MODE: nxt_st.rdata = 32'(st_ff.modeCfg);
                OFS_MISC: nxt_st.rdata = 32'(st_ff.csumDis);
                OFS_HVMODE: nxt_st.rdata = 32'(st_ff.hvMode);
                OFS_RSRV: nxt_st.rdata = 32'(st_ff.rsrv);
                OFS_STAMP: nxt_st.rdata = st_ff.stampVal;
                OFS_EVT: nxt_st.rdata = 32'(st_ff.evt);
                OFS_PHY: nxt_st.rdata = 32'(st_ff.phyPred);
                OFS_PHASE: nxt_st.rdata = 32'(st_ff.phaseEn);
                OFS_SEQIDX: nxt_st.rdata = 32'(st_ff.seqIdx);
                OFS_SEQVAL: nxt_st.rdata = 32'(swSeq);
                OFS_PORTSEL: nxt_st.rdata = 32'(st_ff.portSel);
                OFS_EDLY: nxt_st.rdata = 32'(st_ff.edly[st_ff.portSel]);
                OFS_IDLY1: nxt_st.rdata = 32'(st_ff.idly1[st_ff.portSel]);
                OFS_IDLY2: nxt_st.rdata = 32'(st_ff.idly2[st_ff.portSel]);
                OFS_SAL: nxt_st.rdata = st_ff.smac[st_ff.portSel][31:0];
                OFS_SAH: nxt_st.rdata = 32'(st_ff.smac[st_ff.portSel][47:32]);
                OFS_PCFG: nxt_st.rdata = 32'(st_ff.pcfg[st_ff.portSel]);
                default: nxt_st.rdata = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    prad_seq_table u_seq (
        .clk(clk),
        .reset(reset),
        .frmIdx(headerStampLow),
        .frmBump(seqBump),
        .frmSeq(frmSeq),
        .swIdx(st_ff.seqIdx),
        .swWr(swSeqWr),
        .swData(wd[15:0]),
        .swSeq(swSeq)
    );

    prad_stamp_fifo u_fifo (
        .clk(clk),
        .reset(reset),
        .push(fifoPush),
        .pushData(fifoIn),
        .pop(fifoPop),
        .headData(fifoHead),
        .empty(fifoEmpty),
        .full(fifoFull)
    );

    assign hrdata = st_ff.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign opValid = st_ff.opValid;
    assign opTiming = st_ff.opTiming;
    assign opCfToRx = st_ff.opCfToRx;
    assign opDelay = st_ff.opDelay;
    assign opSeqInsert = st_ff.opSeqInsert;
    assign opSeqNum = st_ff.opSeqNum;
    assign opSwapMac = st_ff.opSwapMac;
    assign opSmacReplace = st_ff.opSmacReplace;
    assign opSmac = st_ff.opSmac;
    assign opCsumDisable = st_ff.opCsumDisable;
    assign opDomain = st_ff.opDomain;

    sequence s_two_step;
        frmValid && aCmd == CMD_TWO;
    endsequence
    sequence s_ing_push;
        fifoPush && fifoIn[STV_ING];
    endsequence

    chk_timing_cmd: assert property (@(posedge clk) disable iff (reset)
        frmValid |=> opValid && opTiming == $past(aCmd))
        else $error("timing command mismatch");
    chk_delay_sel: assert property (@(posedge clk) disable iff (reset)
        frmValid && aDly == DLY_NONE |=> opDelay == '0)
        else $error("delay not zero");
    chk_seq_pick: assert property (@(posedge clk) disable iff (reset)
        frmValid && aSeq == SEQ_UPD |=> opSeqInsert && opSeqNum == $past(frmSeq))
        else $error("sequence pick wrong");
    chk_cf_rx: assert property (@(posedge clk) disable iff (reset)
        frmValid |=> opCfToRx == ($past(aSeq[1]) && $past(aCmd) == CMD_ONE))
        else $error("correction update flag wrong");
    chk_mac_bits: assert property (@(posedge clk) disable iff (reset)
        frmValid |=> opSwapMac == $past(rewriteActionField[ACT_SWAP])
            && opSmacReplace == $past(rewriteActionField[ACT_SMAC]))
        else $error("mac action bits wrong");
    chk_two_order: assert property (@(posedge clk) disable iff (reset)
        s_two_step |-> fifoPush && !fifoIn[STV_ING] ##1 s_ing_push)
        else $error("two-step push order wrong");
    chk_rsrv_sticky: assert property (@(posedge clk) disable iff (reset)
        frmValid && rsrvNonZero |=> st_ff.rsrv[$past(rp)])
        else $error("reserved flag not set");
    chk_evt_sticky: assert property (@(posedge clk) disable iff (reset)
        |cfOverflow |=> (st_ff.evt & $past(cfOverflow)) == $past(cfOverflow))
        else $error("overflow flag not set");
    chk_pop_stamp: assert property (@(posedge clk) disable iff (reset)
        fifoPop && !fifoEmpty |=> st_ff.stampVal == $past(fifoHead))
        else $error("stamp value not loaded");
endmodule
`default_nettype wire

// ### test/prad_classifier_model.sv
/*
 frame classifier stand-in: hands one action field and its side data per
 frame strobe. assumes the decoder samples the fields with the strobe only.
*/
`default_nettype none
module prad_classifier_model
    import prad_pkg::*;
(
    input wire logic clk,
    output logic frmValid,
    output logic [7:0] rewriteActionField,
    output logic [7:0] headerStampLow,
    output logic [PW-1:0] rxPort,
    output logic [PW-1:0] txPort,
    output logic [STAMP_W-1:0] rxStamp,
    output logic [STAMP_W-1:0] txStamp,
    output logic rsrvNonZero
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        frmValid = 1'b0;
        {rewriteActionField, headerStampLow, rxPort, txPort} = '0;
        {rxStamp, txStamp, rsrvNonZero} = '0;
    end
    // action fields go out as given, no extra frames made
    task automatic send(input logic [7:0] act, idx,
            input logic [PW-1:0] rp, tp,
            input logic [STAMP_W-1:0] rs, ts, input logic rz);
        @(posedge clk);
        frmValid <= 1'b1;
        {rewriteActionField, headerStampLow, rxPort, txPort} <= {act, idx, rp, tp};
        {rxStamp, txStamp, rsrvNonZero} <= {rs, ts, rz};
        @(posedge clk);
        // fields scrambled once the strobe is gone
        frmValid <= 1'b0;
        {rewriteActionField, headerStampLow, rxPort, txPort} <= ~{act, idx, rp, tp};
        {rxStamp, txStamp, rsrvNonZero} <= ~{rs, ts, rz};
    endtask
endmodule
`default_nettype wire

// ### test/ptp_rewrite_action_decode_test.sv
/*
 self-checking bench for the timing action decoder: config, random frames,
 stamp fifo, sequence table, sticky flags. assumes zero-wait register bus.
*/
`default_nettype none
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin \
    $display("unexpected %s exp %h got %h", nm, ex, got); failCount++; end end
module ptp_rewrite_action_decode_test
    import prad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, hsel, hwrite, hreadyout, hresp, frmValid, rsrvNonZero;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, opTiming, opDomain;
    logic [2:0] hsize;
    logic [7:0] rewriteActionField, headerStampLow, act;
    logic [PW-1:0] rxPort, txPort;
    logic [STAMP_W-1:0] rxStamp, txStamp;
    logic [NPORT-1:0] cfOverflow;
    logic opValid, opCfToRx, opSeqInsert, opSwapMac, opSmacReplace;
    logic opCsumDisable;
    logic [DLY_W-1:0] opDelay;
    logic [15:0] opSeqNum, mode, seqv [8];
    logic [47:0] opSmac;
    logic [15:0] edly [NPORT], id1 [NPORT], id2 [NPORT], sah [NPORT];
    logic [31:0] sal [NPORT], q [$];
    logic [3:0] csum;
    int failCount = 0;
    int checksDone = 0;
    prad_top uut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .frmValid,
        .rewriteActionField, .headerStampLow, .rxPort, .txPort, .rxStamp,
        .txStamp, .rsrvNonZero, .cfOverflow, .opValid, .opTiming, .opCfToRx,
        .opDelay, .opSeqInsert, .opSeqNum, .opSwapMac, .opSmacReplace, .opSmac,
        .opCsumDisable, .opDomain);
    prad_classifier_model cls (.clk, .frmValid, .rewriteActionField,
        .headerStampLow, .rxPort, .txPort, .rxStamp, .txStamp, .rsrvNonZero);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic testDone;
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0000_0000, rd);
        `CHK($sformatf("reg %h", a), ex, rd)
    endtask
    function automatic logic [15:0] expDly(logic [1:0] s, logic [1:0] rp, tp);
        case (s)
            DLY_EGR: return edly[tp];
            DLY_IN1: return id1[rp];
            DLY_IN2: return id2[rp];
            default: return 16'h0000;
        endcase
    endfunction
    task automatic frame(input logic [7:0] a, input logic [7:0] idx,
            input logic [1:0] rp, tp, input logic rz);
        logic [29:0] rs, ts;
        rs = {2'h0, 28'($urandom)};
        ts = {2'h0, 28'($urandom)};
        cls.send(a, idx, rp, tp, rs, ts, rz);
        @(negedge clk);
        `CHK("valid", 1'b1, opValid)
        `CHK("timing", a[1:0], opTiming)
        `CHK("cftorx", a[5] & (a[1:0] == CMD_ONE), opCfToRx)
        `CHK("delay", expDly(a[3:2], rp, tp), opDelay)
        `CHK("seqins", a[5:4] == SEQ_UPD, opSeqInsert)
        if (a[5:4] == SEQ_UPD) begin
            `CHK("seqnum", seqv[idx], opSeqNum)
            seqv[idx]++;
        end
        `CHK("swap", a[6], opSwapMac)
        `CHK("smacrep", a[7], opSmacReplace)
        `CHK("smac", {sah[tp], sal[tp]}, opSmac)
        `CHK("csum", csum[tp], opCsumDisable)
        `CHK("domain", mode[4*tp+2 +: 2], opDomain)
        if (a[1:0] == CMD_TWO) begin
            q.push_back({2'b10, tp, ts[27:0]});
            q.push_back({2'b11, rp, rs[27:0]});
        end
        @(negedge clk);
        `CHK("pulse", 1'b0, opValid)
    endtask
    initial begin
        #2000000;
        failCount++;
        testDone();
    end
    initial begin
        reset = 1'b1;
        hsel = 1'b1;
        hsize = 3'h2;
        {htrans, hwrite, haddr, hwdata} = '0;
        cfOverflow = 4'h0;
        void'($urandom(42223));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        mode = 16'($urandom);
        csum = 4'($urandom);
        wr(OFS_MODE, {16'h0000, mode});
        wr(OFS_MISC, {28'h000_0000, csum});
        rc(OFS_MODE, {16'h0000, mode});
        rc(OFS_MISC, {28'h000_0000, csum});
        foreach (edly[p]) begin
            {edly[p], id1[p], id2[p], sah[p], sal[p]} = {$urandom, $urandom, $urandom};
            wr(OFS_PORTSEL, p);
            wr(OFS_EDLY, {16'h0000, edly[p]});
            wr(OFS_IDLY1, {16'h0000, id1[p]});
            wr(OFS_IDLY2, {16'h0000, id2[p]});
            wr(OFS_SAL, sal[p]);
            wr(OFS_SAH, {16'h0000, sah[p]});
            rc(OFS_IDLY2, {16'h0000, id2[p]});
            rc(OFS_SAL, sal[p]);
        end
        wr(OFS_HVMODE, 32'h0000_0001);
        rc(OFS_HVMODE, 32'h0000_0001);
        wr(OFS_PHY, 32'h0000_0001);
        rc(OFS_PHY, 32'h0000_0001);
        wr(OFS_PHASE, 32'h0000_0001);
        rc(OFS_PHASE, 32'h0000_0001);
        wr(OFS_PCFG, 32'h0000_A5C3);
        rc(OFS_PCFG, 32'h0000_A5C3);
        wr(12'h0FC, 32'hFFFF_FFFF);
        rc(12'h0FC, 32'h0000_0000);
        $display("test config done");
        foreach (seqv[i]) begin
            seqv[i] = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(OFS_SEQIDX, i);
            wr(OFS_SEQVAL, {16'h0000, seqv[i]});
            rc(OFS_SEQVAL, {16'h0000, seqv[i]});
        end
        for (int i = 0; i < 64; i++) begin
            act = {4'($urandom), 4'(i)};
            frame(act, 8'($urandom_range(7)), 2'($urandom), 2'($urandom), 1'b0);
        end
        frame(8'h10, 8'h00, 2'h1, 2'h2, 1'b0);
        frame(8'h10, 8'h00, 2'h3, 2'h0, 1'b0);
        $display("test frames done");
        foreach (seqv[i]) begin
            wr(OFS_SEQIDX, i);
            rc(OFS_SEQVAL, {16'h0000, seqv[i]});
        end
        while (q.size() > 0) begin
            wr(OFS_POP, 32'h0000_0001);
            rc(OFS_STAMP, q.pop_front());
        end
        wr(OFS_POP, 32'h0000_0001);
        rc(OFS_STAMP, 32'h0000_0000);
        $display("test fifo done");
        rc(OFS_RSRV, 32'h0000_0000);
        frame(8'h01, 8'h01, 2'h2, 2'h1, 1'b1);
        bus(1'b0, OFS_RSRV, 32'h0000_0000, rd);
        `CHK("rsrv", 32'h0000_0004, rd)
        wr(OFS_RSRV, 32'hFFFF_FFFF);
        rc(OFS_RSRV, 32'h0000_0000);
        for (int p = 0; p < NPORT; p++) begin
            @(posedge clk);
            cfOverflow <= 4'(1 << p);
            @(posedge clk);
            cfOverflow <= 4'h0;
            rc(OFS_EVT, 32'(1 << p));
            wr(OFS_EVT, 32'hFFFF_FFFF);
        end
        rc(OFS_EVT, 32'h0000_0000);
        $display("test sticky done");
        testDone();
    end
endmodule
`default_nettype wire
